// >>> cmc_bus_node.sv
// bus node model: wired-and bus with pull-up and bit sample points
`timescale 1ns/1ps
`default_nettype none

module cmc_bus_node (
   input wire logic clk,
   input wire logic reset,
   input wire logic drive_dom,
   input wire logic bus_transmit_pin,
   output logic bus_receive_pin,
   output logic bit_sample_strobe
);
   logic [1:0] div_q;
   // pull-up keeps the bus recessive unless some node drives dominant
   assign bus_receive_pin = bus_transmit_pin & ~drive_dom;
   assign bit_sample_strobe = (div_q == 2'h3);
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
   end
endmodule

`default_nettype wire

// >>> cmc_idle_counter.sv
// counter of consecutive recessive bit samples for bus synchronisation
`timescale 1ns/1ps
`default_nettype none

module cmc_idle_counter #(
   parameter int unsigned IDLE_BITS = cmc_pkg::CMC_IDLE_BITS,
   parameter int unsigned CNT_W = cmc_pkg::CMC_IDLE_CNT_W
)(
   input wire logic clk,
   input wire logic reset,
   input wire logic restart,
   input wire logic sample_strobe,
   input wire logic rx_level,
   output logic bus_idle
);

   localparam logic [CNT_W-1:0] LAST = CNT_W'(IDLE_BITS - 1);

   logic [CNT_W-1:0] count_q;
   logic idle_q;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         count_q <= '0;
         idle_q <= 1'h0;
      end
      else if (restart)
      begin
         count_q <= '0;
         idle_q <= 1'h0;
      end
      else if (sample_strobe && !idle_q)
      begin
         if (rx_level == cmc_pkg::CMC_DOMINANT)
            count_q <= '0;
         else if (count_q == LAST)
            idle_q <= 1'h1;
         else
            count_q <= count_q + CNT_W'(1);
      end
   end

   assign bus_idle = idle_q;

endmodule

`default_nettype wire

// >>> cmc_mode_ctrl.sv
// operating mode controller: init, normal, sleep, wake and test routing
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_ctrl #(
   parameter int unsigned IDLE_BITS = cmc_pkg::CMC_IDLE_BITS,
   parameter int unsigned IDLE_CNT_W = cmc_pkg::CMC_IDLE_CNT_W
)(
   input wire logic clk,
   input wire logic reset,
   input wire logic init_request,
   input wire logic sleep_request_wr,
   input wire logic sleep_request_wdata,
   input wire logic auto_wakeup_enable,
   input wire logic wakeup_irq_enable,
   input wire logic silent_select,
   input wire logic loopback_select,
   input wire logic bit_sample_strobe,
   input wire logic core_tx,
   input wire logic bus_receive_pin,
   output logic sleep_request,
   output logic init_acknowledge,
   output logic sleep_acknowledge,
   output logic normal_mode,
   output logic wakeup_irq,
   output logic core_clock_enable,
   output logic core_bus_enable,
   output logic core_tx_start_enable,
   output logic core_ignore_ack_error,
   output logic test_silent,
   output logic test_loopback,
   output logic core_rx,
   output logic bus_transmit_pin
);

   cmc_pkg::cmc_state_t state_q;
   cmc_pkg::cmc_state_t state_d;

   logic sleep_request_q;
   logic init_ack_q;
   logic sleep_ack_q;
   logic normal_q;
   logic wakeup_irq_q;
   logic clock_en_q;
   logic bus_en_q;
   logic tx_start_en_q;
   logic ignore_ack_q;
   logic silent_q;
   logic loopback_q;
   logic rx_prev_q;

   logic bus_activity;
   logic sync_restart;
   logic bus_idle;
   logic halt_tx;

   // modes in which the core must stay off the bus
   function automatic logic is_halted(input cmc_pkg::cmc_state_t st);
   begin
      is_halted = (st != cmc_pkg::CMC_ST_NORMAL);
   end
   endfunction

   // modes in which the recessive bit count is running
   function automatic logic is_syncing(input cmc_pkg::cmc_state_t st);
   begin
      is_syncing = (st == cmc_pkg::CMC_ST_SYNC) || (st == cmc_pkg::CMC_ST_WAKE);
   end
   endfunction

   // sleep decode, shared by ack, normal flag and clock gate
   function automatic logic is_sleeping(input cmc_pkg::cmc_state_t st);
   begin
      is_sleeping = (st == cmc_pkg::CMC_ST_SLEEP);
   end
   endfunction

   // init decode, shared by ack and normal flag
   function automatic logic is_init(input cmc_pkg::cmc_state_t st);
   begin
      is_init = (st == cmc_pkg::CMC_ST_INIT);
   end
   endfunction

   // activity means a fresh dominant edge on the raw pin; the core clock is
   // stopped so bit strobes cannot be trusted here
   assign bus_activity = (state_q == cmc_pkg::CMC_ST_SLEEP)
                         && (rx_prev_q == cmc_pkg::CMC_RECESSIVE)
                         && (bus_receive_pin == cmc_pkg::CMC_DOMINANT);

   assign sync_restart = !is_syncing(state_q);
   assign halt_tx = is_halted(state_q);

   // next mode
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         cmc_pkg::CMC_ST_SLEEP:
         begin
            // init request is ignored while asleep
            if (!sleep_request_q)
               state_d = cmc_pkg::CMC_ST_WAKE;
         end
         cmc_pkg::CMC_ST_INIT:
         begin
            if (!init_request && sleep_request_q)
               state_d = cmc_pkg::CMC_ST_SLEEP;
            else if (!init_request)
               state_d = cmc_pkg::CMC_ST_SYNC;
         end
         cmc_pkg::CMC_ST_SYNC:
         begin
            if (init_request)
               state_d = cmc_pkg::CMC_ST_INIT;
            else if (sleep_request_q)
               state_d = cmc_pkg::CMC_ST_SLEEP;
            else if (bus_idle)
               state_d = cmc_pkg::CMC_ST_NORMAL;
         end
         cmc_pkg::CMC_ST_WAKE:
         begin
            if (sleep_request_q)
               state_d = cmc_pkg::CMC_ST_SLEEP;
            else if (bus_idle && init_request)
               state_d = cmc_pkg::CMC_ST_INIT;
            else if (bus_idle)
               state_d = cmc_pkg::CMC_ST_NORMAL;
         end
         cmc_pkg::CMC_ST_NORMAL:
         begin
            if (init_request)
               state_d = cmc_pkg::CMC_ST_INIT;
            else if (sleep_request_q)
               state_d = cmc_pkg::CMC_ST_SLEEP;
         end
         default:
         begin
            state_d = cmc_pkg::CMC_STATE_RST;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= cmc_pkg::CMC_STATE_RST;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // sleep request: software writes, hardware clears on auto wakeup;
   // a software write in the same cycle wins
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sleep_request_q <= cmc_pkg::CMC_SLEEP_REQ_RST;
      end
      else if (sleep_request_wr)
      begin
         sleep_request_q <= sleep_request_wdata;
      end
      else if (bus_activity && auto_wakeup_enable)
      begin
         sleep_request_q <= 1'h0;
      end
   end

   // acknowledges follow the mode actually reached, on the same edge as the state;
   // registered from next state so software never sees a half entered mode
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         init_ack_q <= cmc_pkg::CMC_INIT_ACK_RST;
      end
      else
      begin
         init_ack_q <= is_init(state_d);
      end
   end

   // sleep ack set on entry, held through the wake sync, then cleared
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sleep_ack_q <= cmc_pkg::CMC_SLEEP_ACK_RST;
      end
      else if (is_sleeping(state_d))
      begin
         sleep_ack_q <= 1'h1;
      end
      else if (state_d != cmc_pkg::CMC_ST_WAKE)
      begin
         sleep_ack_q <= 1'h0;
      end
   end

   // normal exactly when neither acknowledge is set; decoded from the
   // same next state as the acks so the three never disagree
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         normal_q <= 1'h0;
      end
      else
      begin
         normal_q <= !is_init(state_d)
                     && !is_sleeping(state_d)
                     && (state_d != cmc_pkg::CMC_ST_WAKE);
      end
   end

   // wakeup interrupt pulse, independent of auto wakeup
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wakeup_irq_q <= cmc_pkg::CMC_WAKE_IRQ_RST;
      end
      else
      begin
         wakeup_irq_q <= bus_activity && wakeup_irq_enable;
      end
   end

   // resets to recessive so a bus already dominant at release of reset is taken as activity
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         rx_prev_q <= cmc_pkg::CMC_RX_PREV_RST;
      end
      else
      begin
         rx_prev_q <= bus_receive_pin;
      end
   end

   // core clock gate; status and acks are frozen while it is low
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         clock_en_q <= 1'h0;
      end
      else
      begin
         clock_en_q <= !is_sleeping(state_d);
      end
   end

   // bus traffic only in normal mode, never while halted
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         bus_en_q <= 1'h0;
      end
      else
      begin
         bus_en_q <= !is_halted(state_d);
      end
   end

   // silent mode may answer on the bus only through internal feedback
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tx_start_en_q <= 1'h0;
      end
      else
      begin
         tx_start_en_q <= !is_halted(state_d) && !silent_q;
      end
   end

   // one cycle behind the latched loopback bit, harmless as it only
   // changes in init
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ignore_ack_q <= 1'h0;
      end
      else
      begin
         ignore_ack_q <= loopback_q;
      end
   end

   // test selection is sampled only in init so a live frame never sees
   // its routing change; other configuration is never touched by modes
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         silent_q <= cmc_pkg::CMC_SILENT_RST;
         loopback_q <= cmc_pkg::CMC_LOOPBACK_RST;
      end
      else if (state_q == cmc_pkg::CMC_ST_INIT)
      begin
         silent_q <= silent_select;
         loopback_q <= loopback_select;
      end
   end

   cmc_idle_counter #(
      .IDLE_BITS(IDLE_BITS),
      .CNT_W(IDLE_CNT_W)
   ) u_idle (
      .clk(clk),
      .reset(reset),
      .restart(sync_restart),
      .sample_strobe(bit_sample_strobe),
      .rx_level(core_rx),
      .bus_idle(bus_idle)
   );

   cmc_pin_mux u_mux (
      .clk(clk),
      .reset(reset),
      .halt_tx(halt_tx),
      .silent(silent_q),
      .loopback(loopback_q),
      .core_tx(core_tx),
      .pin_rx(bus_receive_pin),
      .pin_tx(bus_transmit_pin),
      .core_rx(core_rx)
   );

   assign sleep_request = sleep_request_q;
   assign init_acknowledge = init_ack_q;
   assign sleep_acknowledge = sleep_ack_q;
   assign normal_mode = normal_q;
   assign wakeup_irq = wakeup_irq_q;
   assign core_clock_enable = clock_en_q;
   assign core_bus_enable = bus_en_q;
   assign core_tx_start_enable = tx_start_en_q;
   assign core_ignore_ack_error = ignore_ack_q;
   assign test_silent = silent_q;
   assign test_loopback = loopback_q;

endmodule

`default_nettype wire

// >>> cmc_mode_ctrl_monitor.sv
// checker of mode control behaviour at the controller ports
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_ctrl_monitor #(
   parameter int unsigned IDLE_BITS = 11
)(
   input wire logic clk,
   input wire logic reset,
   input wire logic init_request,
   input wire logic sleep_request_wr,
   input wire logic auto_wakeup_enable,
   input wire logic wakeup_irq_enable,
   input wire logic bit_sample_strobe,
   input wire logic core_tx,
   input wire logic bus_receive_pin,
   input wire logic sleep_request,
   input wire logic init_acknowledge,
   input wire logic sleep_acknowledge,
   input wire logic normal_mode,
   input wire logic wakeup_irq,
   input wire logic core_clock_enable,
   input wire logic core_bus_enable,
   input wire logic core_tx_start_enable,
   input wire logic core_ignore_ack_error,
   input wire logic test_silent,
   input wire logic test_loopback,
   input wire logic core_rx,
   input wire logic bus_transmit_pin
);
   logic [3:0] rec_q;
   // saturates so a long idle bus cannot wrap the count
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rec_q <= 4'h0;
      else if (bit_sample_strobe && !core_rx)
         rec_q <= 4'h0;
      else if (bit_sample_strobe && rec_q != 4'hF)
         rec_q <= rec_q + 4'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence bus_act;
      sleep_acknowledge && sleep_request && !core_clock_enable && $fell(bus_receive_pin);
   endsequence
   normal_flag_a: assert property (normal_mode == (!init_acknowledge && !sleep_acknowledge))
      else $error("normal flag wrong");
   init_cause_a: assert property ($rose(init_acknowledge) |-> $past(init_request))
      else $error("init ack without request");
   init_halt_a: assert property (init_acknowledge |-> !core_bus_enable && !core_tx_start_enable)
      else $error("traffic in init");
   init_tx_a: assert property (init_acknowledge && $past(init_acknowledge) |-> bus_transmit_pin)
      else $error("tx not recessive in init");
   sleep_init_a: assert property (sleep_acknowledge |-> !init_acknowledge)
      else $error("init acked asleep");
   sleep_clk_a: assert property (sleep_acknowledge && sleep_request && $past(sleep_request)
      |-> !core_clock_enable)
      else $error("clock runs asleep");
   wake_irq_a: assert property (wakeup_irq_enable ##0 bus_act |=> wakeup_irq)
      else $error("no wakeup irq");
   auto_wake_a: assert property (auto_wakeup_enable && !sleep_request_wr ##0 bus_act
      |=> !sleep_request)
      else $error("no auto wakeup");
   sync_idle_a: assert property ($rose(core_bus_enable) |-> rec_q >= IDLE_BITS)
      else $error("bus enabled before idle");
   sleep_exit_a: assert property ($fell(sleep_acknowledge) |-> rec_q >= IDLE_BITS)
      else $error("sleep left before idle");
   start_en_a: assert property (core_tx_start_enable |-> core_bus_enable && !test_silent)
      else $error("start allowed wrongly");
   silent_tx_a: assert property (test_silent && $past(test_silent) |-> bus_transmit_pin)
      else $error("silent tx dominant");
   loop_rx_a: assert property (test_loopback && core_bus_enable && $past(core_bus_enable)
      |-> core_rx == $past(core_tx))
      else $error("loopback rx wrong");
   ack_ign_a: assert property (core_ignore_ack_error == $past(test_loopback))
      else $error("ack ignore wrong");
   cover property ($rose(wakeup_irq));
   cover property ($fell(sleep_acknowledge));
   cover property (test_loopback && test_silent && core_bus_enable);
endmodule

`default_nettype wire

// >>> cmc_pin_mux.sv
// registered routing of bus pins and core bits for the test modes
`timescale 1ns/1ps
`default_nettype none

module cmc_pin_mux (
   input wire logic clk,
   input wire logic reset,
   input wire logic halt_tx,
   input wire logic silent,
   input wire logic loopback,
   input wire logic core_tx,
   input wire logic pin_rx,
   output logic pin_tx,
   output logic core_rx
);

   logic pin_tx_q;
   logic core_rx_q;
   logic tx_bit;

   // core output is forced recessive while halted so loopback sees idle
   assign tx_bit = halt_tx ? cmc_pkg::CMC_RECESSIVE : core_tx;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         pin_tx_q <= cmc_pkg::CMC_RECESSIVE;
      else if (silent)
         pin_tx_q <= cmc_pkg::CMC_RECESSIVE;
      else
         pin_tx_q <= tx_bit;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         core_rx_q <= cmc_pkg::CMC_RECESSIVE;
      else if (loopback)
         core_rx_q <= tx_bit;
      else if (silent)
         core_rx_q <= pin_rx & tx_bit;
      else
         core_rx_q <= pin_rx;
   end

   assign pin_tx = pin_tx_q;
   assign core_rx = core_rx_q;

endmodule

`default_nettype wire

// >>> cmc_pkg.sv
// constants and types shared by the operating mode controller
// Functional notes
// - hardware reset leaves controller asleep
// - acknowledge bits set only once mode entered
// - normal mode when both acknowledges clear
// - wait eleven recessive bits before normal
// - init acknowledge clears only after leaving init
// - init mode halts traffic, transmit held recessive
// - entering init keeps configuration untouched
// - asleep, clock stopped, status bits frozen
// - init request while asleep not acknowledged
// - wake on software clear or bus activity
// - auto wakeup clears sleep request itself
// - wakeup interrupt on activity, even auto
// - synchronize before clearing sleep acknowledge
// - test selection latched in init, runs normal
// - silent mode receives, transmits only recessive
// - silent dominant bits fed back internally
// - loopback frames received as own frames
// - loopback ignores ack errors, pin disregarded
// - combined mode: rx disconnected, tx recessive

`default_nettype none

package cmc_pkg;

   localparam int unsigned CMC_IDLE_BITS = 11;
   localparam int unsigned CMC_IDLE_CNT_W = 4;

   localparam logic CMC_RECESSIVE = 1'h1;
   localparam logic CMC_DOMINANT = 1'h0;

   localparam logic CMC_SLEEP_REQ_RST = 1'h1;
   localparam logic CMC_SLEEP_ACK_RST = 1'h1;
   localparam logic CMC_INIT_ACK_RST = 1'h0;
   localparam logic CMC_SILENT_RST = 1'h0;
   localparam logic CMC_LOOPBACK_RST = 1'h0;
   localparam logic CMC_WAKE_IRQ_RST = 1'h0;
   localparam logic CMC_RX_PREV_RST = 1'h1;

   typedef enum logic [4:0] {
      CMC_ST_SLEEP = 5'h01,
      CMC_ST_INIT = 5'h02,
      CMC_ST_SYNC = 5'h04,
      CMC_ST_WAKE = 5'h08,
      CMC_ST_NORMAL = 5'h10
   } cmc_state_t;

   localparam cmc_state_t CMC_STATE_RST = CMC_ST_SLEEP;

endpackage

`default_nettype wire

// >>> tb_top.sv
// testbench for the operating mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin #1; check_count++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
`define WT(e) begin k = 0; while (!(e) && k < 400) begin @(posedge clk); #1; k++; end \
   if (k == 400) begin n_fail++; results(); end end

module tb_top;
   logic clk = 1'h0, reset = 1'h1, init_request = 1'h0, sleep_request_wr = 1'h0;
   logic sleep_request_wdata = 1'h0, auto_wakeup_enable = 1'h0, wakeup_irq_enable = 1'h1;
   logic silent_select = 1'h0, loopback_select = 1'h0, core_tx = 1'h1, drive_dom = 1'h0;
   logic bit_sample_strobe, bus_receive_pin, sleep_request, init_acknowledge, sleep_acknowledge;
   logic normal_mode, wakeup_irq, core_clock_enable, core_bus_enable, core_tx_start_enable;
   logic core_ignore_ack_error, test_silent, test_loopback, core_rx, bus_transmit_pin;
   int n_fail = 0, check_count = 0, k;
   always #10 clk = ~clk;
   cmc_mode_ctrl DUT (.*);
   cmc_bus_node u_node (.*);
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_sleep(input logic v);
      @(posedge clk);
      sleep_request_wr <= 1'h1;
      sleep_request_wdata <= v;
      @(posedge clk);
      sleep_request_wr <= 1'h0;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // generous bound, the sequence needs about five hundred cycles
   initial
   begin
      #100000;
      n_fail++;
      results();
   end
   initial
   begin
      tick(16);
      reset <= 1'h0;
      tick(2);
      `CHK(sleep_acknowledge, 1'h1)
      `CHK(normal_mode, 1'h0)
      tick(1);
      init_request <= 1'h1;
      tick(4);
      `CHK(init_acknowledge, 1'h0)
      tick(1);
      init_request <= 1'h0;
      wr_sleep(1'h0);
      tick(1);
      `CHK(sleep_request, 1'h0)
      tick(8);
      drive_dom <= 1'h1;
      tick(5);
      drive_dom <= 1'h0;
      `WT(!sleep_acknowledge)
      `CHK(normal_mode, 1'h1)
      for (int m = 0; m < 4; m++)
      begin
         tick(1);
         init_request <= 1'h1;
         `WT(init_acknowledge)
         tick(1);
         core_tx <= 1'h0;
         tick(2);
         `CHK(bus_transmit_pin, 1'h1)
         tick(1);
         core_tx <= 1'h1;
         silent_select <= m[0];
         loopback_select <= m[1];
         tick(2);
         init_request <= 1'h0;
         `WT(core_bus_enable)
         `CHK(test_silent, m[0])
         `CHK(core_tx_start_enable, !m[0])
         `CHK(core_ignore_ack_error, m[1])
         tick(1);
         core_tx <= 1'h0;
         tick(2);
         `CHK(bus_transmit_pin, m[0])
         `CHK(core_rx, 1'h0)
         tick(1);
         core_tx <= 1'h1;
         drive_dom <= 1'h1;
         tick(2);
         `CHK(core_rx, m[1])
         tick(1);
         drive_dom <= 1'h0;
      end
      tick(1);
      auto_wakeup_enable <= 1'h1;
      wr_sleep(1'h1);
      tick(3);
      `CHK(sleep_acknowledge, 1'h1)
      `CHK(core_clock_enable, 1'h0)
      tick(1);
      drive_dom <= 1'h1;
      `WT(wakeup_irq)
      `CHK(sleep_request, 1'h0)
      tick(1);
      drive_dom <= 1'h0;
      `WT(!sleep_acknowledge)
      `CHK(normal_mode, 1'h1)
      tick(1);
      auto_wakeup_enable <= 1'h0;
      wr_sleep(1'h1);
      tick(3);
      drive_dom <= 1'h1;
      `WT(wakeup_irq)
      tick(3);
      `CHK(sleep_request, 1'h1)
      `CHK(sleep_acknowledge, 1'h1)
      tick(1);
      drive_dom <= 1'h0;
      wr_sleep(1'h0);
      `WT(!sleep_acknowledge)
      `CHK(normal_mode, 1'h1)
      results();
   end
endmodule

bind cmc_mode_ctrl cmc_mode_ctrl_monitor #(.IDLE_BITS(IDLE_BITS)) u_mon (.*);

`default_nettype wire
